// >>> cic_pkg.sv
// Purpose: shared constants and types for the interrupt/reset control sequencer
// Assumes: one clock, synchronous active-low reset
// Notes:   one machine cycle is two clocks, phase one then phase two
package cic_pkg;
  // vector bases, low byte here and high byte at the next address
  localparam logic [15:0] VEC_NMI    = 16'hFFFA;
  localparam logic [15:0] VEC_RST    = 16'hFFFC;
  localparam logic [15:0] VEC_IRQ    = 16'hFFFE;
  localparam logic [15:0] VEC_STEP   = 16'h0001;
  localparam logic [15:0] ADDR_RST   = 16'h0000;
  localparam logic [7:0]  STACK_PAGE = 8'h01;
  // machine cycles of the reset initialisation period
  localparam int          INIT_CYCLES = 6;
  localparam logic [2:0]  INIT_LAST   = 3'(INIT_CYCLES - 1);
  // three pushes: pc high, pc low, status
  localparam logic [1:0]  PUSH_LAST   = 2'h2;
  localparam logic [1:0]  PIDX_PCH    = 2'h0;
  localparam logic [1:0]  PIDX_PCL    = 2'h1;
  // status byte field masks
  localparam logic [7:0]  STAT_OVF    = 8'h40;
  localparam logic [7:0]  STAT_MASK   = 8'h04;
  // values after reset
  localparam logic        MASK_RST    = 1'b1;
  localparam logic        OVF_RST     = 1'b0;
  localparam logic [7:0]  BYTE_RST    = 8'h00;

  typedef enum logic [5:0] {
    S_RESET = 6'h01,
    S_INIT  = 6'h02,
    S_RUN   = 6'h04,
    S_PUSH  = 6'h08,
    S_VLO   = 6'h10,
    S_VHI   = 6'h20
  } cic_state_t;

  // core's request for the next bus cycle, and end-of-instruction mark
  typedef struct packed {
    logic [15:0] addr;
    logic        write;
    logic        opfetch;
    logic        done;
    logic [7:0]  wdata;
  } cic_core_req_t;

  // bus cycle as driven at the pins
  typedef struct packed {
    logic [15:0] addr;
    logic        write;
    logic        sync;
    logic [7:0]  data;
  } cic_bus_t;
endpackage

// >>> cic_ctrl.sv
// Purpose: control-pin sequencer: nmi/irq entry, overflow set, sync, ready, reset
// Assumes: all pin inputs synchronous to REF_CLK_IN; core supplies bus requests
// Notes:   phase one is the clock with ph low, phase two the clock with ph high
// Functional notes
// (RL1) nmi falling edge registers a request
// (RL2) nmi runs irq sequence ignoring mask
// (RL3) nmi vector low FFFA, high FFFB
// (RL4) interrupts sampled phase two, start next cycle
// (RL5) overflow-set falling edge sets overflow, phase one
// (RL6) sync high through each opcode fetch cycle
// (RL7) ready low at sync phase one freezes
// (RL8) no writes while reset held low
// (RL9) reset release starts reset sequence immediately
// (RL10) six init cycles, set mask, vector FFFC/FFFD
// (RL11) system holds reset low two clocks minimum
// (RL12) irq with mask clear: push, mask, FFFE/FFFF
// (RL13) irq only after instruction end, ready high
// (RL14) ready low halts reads, ignored on writes
// (RL15) one sequence per edge; reset, nmi, irq priority
// (RL16) vector low byte then high, consecutive addresses
`timescale 1ns/1ps
module cic_ctrl
  import cic_pkg::*;
(
  // clock and reset
  input  wire logic                   REF_CLK_IN,
  input  wire logic                   NRST_IN,
  // control pins
  input  wire logic                   NMI_N_IN,
  input  wire logic                   IRQ_N_IN,
  input  wire logic                   RDY_IN,
  input  wire logic                   SET_OVF_N_IN,
  // data bus
  input  wire logic [7:0]             DATA_IN,
  output logic      [7:0]             DATA_OUT,
  output logic                        DATA_OE_OUT,
  // bus outputs
  output logic      [15:0]            ADDR_OUT,
  output logic                        RW_OUT,
  output logic                        SYNC_OUT,
  output logic                        PHI1_OUT,
  output logic                        PHI2_OUT,
  // core side
  input  wire cic_pkg::cic_core_req_t CORE_REQ_IN,
  input  wire logic [15:0]            PC_IN,
  input  wire logic [7:0]             SP_IN,
  input  wire logic [7:0]             CORE_P_IN,
  input  wire logic                   CLR_MASK_IN,
  input  wire logic                   CLR_OVF_IN,
  output logic                        CORE_ADV_OUT,
  output logic                        PC_LOAD_OUT,
  output logic      [15:0]            VEC_PC_OUT,
  output logic                        SEQ_BUSY_OUT,
  output logic                        MASK_FLAG_OUT,
  output logic                        OVF_FLAG_OUT
);
  import cic_pkg::*;

  cic_state_t  state;
  cic_state_t  next_state;
  cic_bus_t    bus;
  cic_bus_t    next_bus;
  logic        ph;
  logic        halted;
  logic        nmi_prev;
  logic        irq_smp_n;
  logic        rdy_smp;
  logic        so_prev;
  logic        nmi_pend;
  logic        mask;
  logic        ovf;
  logic        vec_is_nmi;
  logic [15:0] vec_base;
  logic [15:0] pc_hold;
  logic [7:0]  vec_lo;
  logic [7:0]  sp_cnt;
  logic [1:0]  push_cnt;
  logic [2:0]  init_cnt;
  logic        doe;

  // event and decision decode
  wire       cyc_end   = ph && !halted;
  wire       nmi_fall  = ph && nmi_prev && !NMI_N_IN;
  wire       so_fall   = !ph && so_prev && !SET_OVF_N_IN;
  wire       take_irq  = !irq_smp_n && !mask && rdy_smp;
  wire       inst_end  = cyc_end && (state == S_RUN) && CORE_REQ_IN.done;
  wire       take_int  = inst_end && (nmi_pend || take_irq);
  wire       nmi_take  = take_int && nmi_pend;
  wire       init_done = (state == S_INIT) && cyc_end && (init_cnt == INIT_LAST);
  wire       push_done = (state == S_PUSH) && cyc_end && (push_cnt == PUSH_LAST);
  wire       enter_vec = init_done || push_done;
  // push sequencing
  wire [1:0] next_pidx = take_int ? PIDX_PCH : 2'(push_cnt + 2'h1);
  wire [7:0] next_sp   = take_int ? SP_IN : 8'(sp_cnt - 8'h01);
  wire [7:0] stat_byte = (CORE_P_IN & ~(STAT_OVF | STAT_MASK))
                       | (ovf ? STAT_OVF : BYTE_RST) | (mask ? STAT_MASK : BYTE_RST);
  wire [7:0] push_byte = (next_pidx == PIDX_PCH) ? PC_IN[15:8]
                       : (next_pidx == PIDX_PCL) ? pc_hold[7:0] : stat_byte; // RL12
  wire [15:0] vec_hi_addr = 16'(vec_base + VEC_STEP);

  // sequencer state; reset dominates everything, then nmi over irq
  always_comb
  begin
    next_state = state;
    unique case (state)
      S_RESET: next_state = S_INIT; // RL9
      S_INIT:  if (init_done) next_state = S_VLO; // RL10
      S_RUN:   if (take_int) next_state = S_PUSH; // RL2 RL12 RL13 RL15
      S_PUSH:  if (push_done) next_state = S_VLO;
      S_VLO:   if (cyc_end) next_state = S_VHI; // RL16
      S_VHI:   if (cyc_end) next_state = S_RUN;
    endcase
  end

  // bus cycle for the machine cycle that starts after this boundary
  always_comb
  begin
    next_bus = bus;
    if (cyc_end || state == S_RESET)
    begin
      next_bus = '{addr: bus.addr, write: 1'b0, sync: 1'b0, data: BYTE_RST};
      unique case (next_state)
        S_RUN:
        begin
          if (state == S_VHI)
          begin
            next_bus.addr = {DATA_IN, vec_lo}; // RL16
            next_bus.sync = 1'b1;
          end
          else
          begin
            next_bus.addr  = CORE_REQ_IN.addr;
            next_bus.write = CORE_REQ_IN.write;
            next_bus.sync  = CORE_REQ_IN.opfetch; // RL6
            next_bus.data  = CORE_REQ_IN.wdata;
          end
        end
        S_PUSH:
        begin
          next_bus.addr  = {STACK_PAGE, next_sp};
          next_bus.write = 1'b1;
          next_bus.data  = push_byte;
        end
        S_VLO:   next_bus.addr = (state == S_INIT) ? VEC_RST : vec_base; // RL3 RL10
        S_VHI:   next_bus.addr = vec_hi_addr; // RL16
        S_RESET, S_INIT: next_bus.addr = bus.addr;
      endcase
    end
  end

  // phase generator; reset leaves the next clock in phase one
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN) ph <= 1'b0;
    else          ph <= !ph;
  end

  // ready looked at in phase one; a write cycle never stalls
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN) halted <= 1'b0;
    else if (!ph) halted <= !RDY_IN && !bus.write; // RL7 RL14
  end

  // phase-two sampling of the interrupt and ready inputs
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      nmi_prev  <= 1'b1;
      irq_smp_n <= 1'b1;
      rdy_smp   <= 1'b0;
    end
    else if (ph)
    begin
      nmi_prev  <= NMI_N_IN; // RL4
      irq_smp_n <= IRQ_N_IN; // RL4
      rdy_smp   <= RDY_IN;
    end
  end

  // overflow-set input taken at the end of phase one
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)  so_prev <= 1'b1;
    else if (!ph)  so_prev <= SET_OVF_N_IN; // RL5
  end

  // sticky flags: a new event beats a same-cycle clear
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      nmi_pend <= 1'b0;
      mask     <= MASK_RST;
      ovf      <= OVF_RST;
    end
    else
    begin
      nmi_pend <= nmi_fall || (nmi_pend && !nmi_take); // RL1 RL15
      mask     <= enter_vec || (mask && !CLR_MASK_IN); // RL10 RL12
      ovf      <= so_fall || (ovf && !CLR_OVF_IN); // RL5
    end
  end

  // state, counters and vector selection
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      state      <= S_RESET;
      init_cnt   <= 3'h0;
      push_cnt   <= 2'h0;
      sp_cnt     <= BYTE_RST;
      vec_base   <= VEC_RST;
      vec_is_nmi <= 1'b0;
    end
    else
    begin
      state <= next_state;
      if (state == S_INIT && cyc_end) init_cnt <= 3'(init_cnt + 3'h1);
      if (take_int || (state == S_PUSH && cyc_end))
      begin
        push_cnt <= next_pidx;
        sp_cnt   <= next_sp;
      end
      if (take_int)
      begin
        vec_base   <= nmi_pend ? VEC_NMI : VEC_IRQ; // RL2 RL3 RL12 RL15
        vec_is_nmi <= nmi_pend;
        pc_hold    <= PC_IN; // core moves on at the take, so keep the pc whole
      end
    end
  end

  // bus pins; reset forces read so nothing is written while held
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      bus <= '{addr: ADDR_RST, write: 1'b0, sync: 1'b0, data: BYTE_RST}; // RL8
      doe <= 1'b0; // RL8
    end
    else
    begin
      bus <= next_bus;
      doe <= !ph && bus.write;
    end
  end

  // vector capture and core handshake pulses
  always_ff @(posedge REF_CLK_IN)
  begin
    if (!NRST_IN)
    begin
      vec_lo       <= BYTE_RST;
      VEC_PC_OUT   <= ADDR_RST;
      PC_LOAD_OUT  <= 1'b0;
      CORE_ADV_OUT <= 1'b0;
      SEQ_BUSY_OUT <= 1'b1;
      PHI1_OUT     <= 1'b1;
    end
    else
    begin
      if (state == S_VLO && cyc_end) vec_lo <= DATA_IN;
      if (state == S_VHI && cyc_end) VEC_PC_OUT <= {DATA_IN, vec_lo};
      PC_LOAD_OUT  <= (state == S_VHI) && cyc_end;
      CORE_ADV_OUT <= cyc_end && (state == S_RUN || state == S_VHI);
      SEQ_BUSY_OUT <= next_state != S_RUN;
      PHI1_OUT     <= ph;
    end
  end

  // pin drive straight from flops
  assign ADDR_OUT      = bus.addr;
  assign RW_OUT        = !bus.write;
  assign SYNC_OUT      = bus.sync;
  assign DATA_OUT      = bus.data;
  assign DATA_OE_OUT   = doe;
  assign PHI2_OUT      = ph;
  assign MASK_FLAG_OUT = mask;
  assign OVF_FLAG_OUT  = ovf;
  // checks
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (!NRST_IN);
  property p_nmi_edge;
    nmi_fall |=> nmi_pend;
  endproperty
  a_nmi_edge: assert property (p_nmi_edge) else $error("nmi edge lost"); // RL1
  property p_nmi_unmasked;
    (inst_end && nmi_pend && mask) |=> (state == S_PUSH) && vec_is_nmi;
  endproperty
  a_nmi_unmasked: assert property (p_nmi_unmasked) else $error("nmi blocked"); // RL2
  // held per state, so a ready halt inside the vector fetch cannot trip it
  property p_nmi_vec;
    ((state == S_VLO) || (state == S_VHI)) && vec_is_nmi
      |-> ADDR_OUT == ((state == S_VLO) ? VEC_NMI : 16'hFFFB);
  endproperty
  a_nmi_vec: assert property (p_nmi_vec) else $error("bad nmi vector"); // RL3
  property p_sample_ph2;
    !ph |=> $stable(irq_smp_n) && $stable(nmi_prev);
  endproperty
  a_sample_ph2: assert property (p_sample_ph2) else $error("sampled off phase"); // RL4
  property p_so_set;
    so_fall |=> ovf;
  endproperty
  a_so_set: assert property (p_so_set) else $error("overflow not set"); // RL5
  property p_sync_cycle;
    $rose(SYNC_OUT) |-> !ph ##1 SYNC_OUT;
  endproperty
  a_sync_cycle: assert property (p_sync_cycle) else $error("sync phase wrong"); // RL6
  property p_ready_halt;
    (!ph && !RDY_IN && RW_OUT) |=> halted ##1 $stable(ADDR_OUT);
  endproperty
  a_ready_halt: assert property (p_ready_halt) else $error("no halt"); // RL7
  property p_write_no_halt;
    (!ph && !RW_OUT) |=> !halted;
  endproperty
  a_write_no_halt: assert property (p_write_no_halt) else $error("write halted"); // RL14
  property p_rst_no_write;
    @(posedge REF_CLK_IN) disable iff (1'b0) !NRST_IN |=> RW_OUT && !DATA_OE_OUT;
  endproperty
  a_rst_no_write: assert property (p_rst_no_write) else $error("write in reset"); // RL8
  property p_rst_vec;
    init_done |=> mask && (ADDR_OUT == VEC_RST) && (init_cnt == 3'(INIT_CYCLES));
  endproperty
  a_rst_vec: assert property (p_rst_vec) else $error("bad reset entry"); // RL10
  property p_irq_gate;
    (inst_end && !nmi_pend && (mask || !rdy_smp)) |=> state == S_RUN;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq taken wrongly"); // RL13
  property p_vec_pair;
    (state == S_VLO && cyc_end) |=> ADDR_OUT == 16'($past(ADDR_OUT) + VEC_STEP);
  endproperty
  a_vec_pair: assert property (p_vec_pair) else $error("vector order"); // RL16
  c_cv_nmi:  cover property (nmi_take);
  c_cv_irq:  cover property (take_int && !nmi_pend);
  c_cv_step: cover property (SYNC_OUT && halted);
  c_cv_boot: cover property (PC_LOAD_OUT && !vec_is_nmi);
endmodule

// >>> cic_mem_model.sv
// Purpose: system memory stand-in answering the device's read cycles
// Assumes: read data is a fixed hash of the address
// Notes:   writes are absorbed; a write cycle shows the inverted low address byte
`timescale 1ns/1ps
module cic_mem_model
(
  // bus from the device
  input  wire logic [15:0] ADDR_IN,
  input  wire logic        RW_IN,
  // read data back
  output logic      [7:0]  DATA_OUT
);
  // inverted pattern off reads so a stale byte never passes
  assign DATA_OUT = RW_IN ? (ADDR_IN[7:0] ^ ADDR_IN[15:8] ^ 8'h5A) : ~ADDR_IN[7:0];
endmodule

// >>> test_cic_ctrl.sv
// Purpose: self-checking bench for the interrupt and reset sequencer
// Assumes: bench plays the core and the system control pins
// Notes:   addresses and interrupt timing random from a fixed seed
`timescale 1ns/1ps
module test_cic_ctrl;
  import cic_pkg::*;
  // pins and core side
  logic          clk = 1'b0, nrst = 1'b0, nmi_n = 1'b1, irq_n = 1'b1, rdy = 1'b1;
  logic          so_n = 1'b1, clr_mask = 1'b0, clr_ovf = 1'b0;
  logic          data_oe, rw, sync, adv, pc_load, mask, ovf, busy, phi1, phi2;
  logic [7:0]    data_in, wdata, sp = 8'hFF, cp = 8'h00;
  logic [15:0]   addr, vec_pc, a;
  cic_core_req_t req = '{16'h0200, 1'b0, 1'b1, 1'b1, 8'h00};
  int            n_mismatch = 0, n_checks = 0, seed = 66, nwr = 0, nld = 0, nadv = 0, i;

  always #5 clk = ~clk;

  cic_mem_model i_cic_mem_model (.ADDR_IN(addr), .RW_IN(rw), .DATA_OUT(data_in));
  cic_ctrl i_cic_ctrl (.REF_CLK_IN(clk), .NRST_IN(nrst), .NMI_N_IN(nmi_n), .IRQ_N_IN(irq_n),
    .RDY_IN(rdy), .SET_OVF_N_IN(so_n), .DATA_IN(data_in), .DATA_OUT(wdata),
    .DATA_OE_OUT(data_oe), .ADDR_OUT(addr), .RW_OUT(rw), .SYNC_OUT(sync), .PHI1_OUT(phi1),
    .PHI2_OUT(phi2),
    .CORE_REQ_IN(req), .PC_IN(req.addr), .SP_IN(sp), .CORE_P_IN(cp), .CLR_MASK_IN(clr_mask),
    .CLR_OVF_IN(clr_ovf), .CORE_ADV_OUT(adv), .PC_LOAD_OUT(pc_load), .VEC_PC_OUT(vec_pc),
    .SEQ_BUSY_OUT(busy), .MASK_FLAG_OUT(mask), .OVF_FLAG_OUT(ovf));

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // expected memory byte, worked out independently of the model
  function automatic logic [7:0] mem(input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ 8'h5A;
  endfunction

  // core stand-in: new random request after each core advance pulse (run and vector-high cycles only)
  always @(posedge clk)
  begin
    nwr <= nwr + int'(data_oe);
    nld <= nld + int'(pc_load);
    nadv <= nadv + int'(adv);
    if (adv)
    begin
      req <= '{16'($random(seed)), 1'b0, 1'($random(seed)), 1'b1, 8'($random(seed))};
      sp <= 8'($random(seed));
      cp <= 8'($random(seed));
    end
  end

  // bus watch: sync follows the fetch flag, loads land on the vector
  always @(negedge clk)
  begin
    if (!nrst)
      check("write in reset", {14'h0, rw, data_oe}, 16'h0002);
    else if (pc_load)
      check("load fetch", {addr[14:0], sync}, {vec_pc[14:0], 1'b1});
    else if (adv && busy)
    begin
      // first stacking cycle: pc high to the stack top, a write without sync
      check("push addr", addr, {STACK_PAGE, sp});
      check("push data", {wdata, 6'h00, rw, sync}, {req.addr[15:8], 8'h00});
    end
    else if (adv)
      check("sync", {13'h0, phi1, phi2, sync}, {13'h0, 2'h2, req.opfetch});
  end

  // wait for a vector load, count stacking writes
  task automatic take(input string what, input logic [15:0] base, input int wr);
    int w0;
    w0 = nwr;
    i = 0;
    while (pc_load !== 1'b1 && i < 300)
    begin
      @(negedge clk);
      i++;
    end
    check("load seen", {15'h0, pc_load}, 16'h0001);
    check(what, vec_pc, {mem(base + 16'h0001), mem(base)});
    check("pushes", 16'(nwr - w0), 16'(wr));
    check("mask", {15'h0, mask}, 16'h0001);
    // let the load pulse reach the counters, and go back to a rising edge
    repeat (2) @(posedge clk);
  endtask

  task automatic do_reset(input int len);
    nrst <= 1'b0;
    repeat (len) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 20 && addr !== VEC_RST; i++) @(posedge clk);
    check("init length", 16'(i >= 12 && i <= 14), 16'h0001);
    while (addr === VEC_RST) @(posedge clk);
    check("vector high", addr, VEC_RST + 16'h0001);
    take("reset", VEC_RST, 0);
  endtask

  // watchdog: the whole run needs a few thousand cycles at most
  initial
  begin
    #100000;
    n_mismatch++;
    summarize();
  end

  initial
  begin
    do_reset(12);
    // mask set after reset: a held request is refused
    a = 16'(nld);
    irq_n <= 1'b0;
    repeat (60) @(posedge clk);
    check("irq masked", 16'(nld), a);
    clr_mask <= 1'b1;
    @(posedge clk);
    clr_mask <= 1'b0;
    take("irq", VEC_IRQ, 3);
    irq_n <= 1'b1;
    // nmi under mask, one sequence per edge
    repeat (3)
    begin
      repeat (2 + ($random(seed) & 15)) @(posedge clk);
      nmi_n <= 1'b0;
      take("nmi", VEC_NMI, 3);
      a = 16'(nld);
      repeat (80) @(posedge clk);
      check("nmi once", 16'(nld), a);
      nmi_n <= 1'b1;
    end
    // both together with mask clear: nmi wins; nmi high must meet a phase-two edge
    clr_mask <= 1'b1;
    repeat (2) @(posedge clk);
    clr_mask <= 1'b0;
    nmi_n <= 1'b0;
    irq_n <= 1'b0;
    take("both", VEC_NMI, 3);
    nmi_n <= 1'b1;
    irq_n <= 1'b1;
    // ready low freezes the bus
    while (sync !== 1'b1) @(posedge clk);
    rdy <= 1'b0;
    repeat (4) @(posedge clk);
    a = addr;
    i = nadv;
    repeat (16) @(posedge clk);
    check("halt addr", addr, a);
    check("halt adv", 16'(nadv - i), 16'h0000);
    rdy <= 1'b1;
    repeat (10) @(posedge clk);
    check("resume", 16'(nadv > i), 16'h0001);
    // overflow set on edge only
    so_n <= 1'b0;
    repeat (4) @(posedge clk);
    check("ovf set", {15'h0, ovf}, 16'h0001);
    clr_ovf <= 1'b1;
    @(posedge clk);
    clr_ovf <= 1'b0;
    repeat (4) @(posedge clk);
    check("ovf level", {15'h0, ovf}, 16'h0000);
    so_n <= 1'b1;
    // reset in mid-run
    do_reset(4);
    summarize();
  end
endmodule
